// File: hdl/window_defines.svh
// Register offsets, field positions, reset values and bus codes.
`ifndef WINDOW_DEFINES_SVH
`define WINDOW_DEFINES_SVH

// Byte offsets of the window registers on the register bus.
`define OFF_CONTROL 12'h13c
`define OFF_BASE 12'h140
`define OFF_BOUND 12'h144
`define OFF_OFFSET 12'h148

// Bit positions of the control word fields.
`define CTL_ENABLE 31
`define CTL_POSTED 30
`define CTL_WIDTH_HI 23
`define CTL_WIDTH_LO 22
`define CTL_SPACE_HI 18
`define CTL_SPACE_LO 16
`define CTL_PROGRAM 14
`define CTL_SUPER 12
`define CTL_BLOCK 8
`define CTL_PCI_SPACE 0

// Address fields occupy the upper half of base, bound and offset.
`define ADDR_FIELD_HI 31
`define ADDR_FIELD_LO 16

// Reset values of the control fields and of the base, bound and offset fields.
`define RST_WIDTH 2'h2
`define RST_SPACE 3'h0
`define RST_ENABLE 1'h0
`define RST_PCI_SPACE 1'h0
`define RST_FIELD 16'h0000

// Register bus response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hdl/window_pkg.sv
// Types shared by the target window logic.
package window_pkg;

  // Address space driven on the far bus.
  typedef enum logic [2:0] {
    SPACE_A16 = 3'b000,
    SPACE_A24 = 3'b001,
    SPACE_A32 = 3'b010,
    SPACE_RSV3 = 3'b011,
    SPACE_RSV4 = 3'b100,
    SPACE_CFG = 3'b101,
    SPACE_USER1 = 3'b110,
    SPACE_USER2 = 3'b111
  } space_t;

  // Largest data width used on the far bus.
  typedef enum logic [1:0] {
    WIDTH_8 = 2'b00,
    WIDTH_16 = 2'b01,
    WIDTH_32 = 2'b10,
    WIDTH_64 = 2'b11
  } width_t;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    SEL_CONTROL = 3'b000,
    SEL_BASE = 3'b001,
    SEL_BOUND = 3'b010,
    SEL_OFFSET = 3'b011,
    SEL_NONE = 3'b100
  } reg_sel_t;

  // Whole state of the window block.
  typedef struct packed {
    logic en;
    logic posted_write_allow;
    logic [1:0] width;
    logic [2:0] vme_space_select;
    logic program_data_am;
    logic sup;
    logic block_transfer_select;
    logic pci_space_select;
    logic [15:0] base;
    logic [15:0] bound;
    logic [15:0] toff;
    logic aw_got;
    logic w_got;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic fwd_valid;
    logic fwd_hit;
    logic [31:0] fwd_addr;
    logic [2:0] fwd_space;
    logic [1:0] fwd_width;
    logic fwd_program;
    logic fwd_super;
    logic fwd_blt;
    logic fwd_mblt;
    logic fwd_posted;
  } window_state_t;

endpackage : window_pkg

// File: hdl/window_decoder.sv
// Address compare and translation for one target window.
`timescale 1ns/1ps
`include "window_defines.svh"

module window_decoder (
  // Incoming access.
  input wire logic [31:0] pci_addr,
  input wire logic pci_io,
  // Window setup.
  input wire logic enable,
  input wire logic pci_space_select,
  input wire logic space_ok,
  input wire logic [15:0] base,
  input wire logic [15:0] bound,
  input wire logic [15:0] toff,
  // Decode result.
  output logic hit,
  output logic [31:0] vme_addr
);

  // Upper half of the incoming address, the only part compared.
  logic [15:0] upper;
  // Lower and upper limit tests.
  logic above_base;
  logic below_bound;

  assign upper = pci_addr[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
  assign above_base = (upper >= base);
  // A zero bound removes the upper limit altogether.
  assign below_bound = (bound == 16'h0000) || (upper < bound);

  // A disabled window, or one of the wrong PCI space, claims nothing.
  assign hit = enable && (pci_io == pci_space_select) && space_ok &&
    above_base && below_bound;

  // The carry out of the sum is dropped by the 16-bit cast.
  assign vme_addr = {16'(upper + toff),
    pci_addr[`ADDR_FIELD_LO-1:0]};

endmodule : window_decoder

// File: hdl/pci_to_vme_target_window.sv
// Register file and decode for one PCI-to-VME target window.
// Operation
// - Block-transfer bit only for A24/A32 narrow widths.
// - A24/A32 with 64-bit allows multiplexed block transfers.
// - PCI I/O window ignores posting, always coupled.
// - Width field 23:22 encodes 8/16/32/64, resets 10.
// - Space field 18:16 selects A16..User2.
// - Bit 14 selects data or program attribute.
// - Bit 12 selects user or supervisor attribute.
// - Bit 8 forbids or permits block transfers.
// - Bit 0 selects PCI memory or I/O.
// - Base bits 31:16, low half reads zero.
// - Claim at or above base, below bound.
// - Zero bound means no upper limit.
// - VME upper address is PCI plus offset.
`timescale 1ns/1ps
`include "window_defines.svh"

module pci_to_vme_target_window (
  // Clock and synchronous active low reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write address and data.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Register bus write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus read.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Access offered by the PCI target side.
  input wire logic pci_valid,
  input wire logic [31:0] pci_addr,
  input wire logic pci_write,
  input wire logic pci_io,
  // Decode result handed to the VME master side.
  output logic fwd_valid,
  output logic fwd_hit,
  output logic [31:0] fwd_vme_addr,
  output logic [2:0] fwd_space,
  output logic [1:0] fwd_width,
  output logic fwd_program,
  output logic fwd_supervisor,
  output logic fwd_blt,
  output logic fwd_mblt,
  output logic fwd_posted
);

  // Present and next state.
  window_pkg::window_state_t s;
  window_pkg::window_state_t next_s;
  // Combinational decode result.
  logic dec_hit;
  logic [31:0] dec_addr;
  // Space code is a defined, non-reserved one.
  logic space_ok;

  // Maps a bus address onto a register of the window.
  function automatic window_pkg::reg_sel_t reg_select(
    input logic [11:0] addr);
    window_pkg::reg_sel_t sel;
    sel = window_pkg::SEL_NONE;
    if (addr == `OFF_CONTROL) begin
      sel = window_pkg::SEL_CONTROL;
    end else if (addr == `OFF_BASE) begin
      sel = window_pkg::SEL_BASE;
    end else if (addr == `OFF_BOUND) begin
      sel = window_pkg::SEL_BOUND;
    end else if (addr == `OFF_OFFSET) begin
      sel = window_pkg::SEL_OFFSET;
    end
    return sel;
  endfunction : reg_select

  // Builds the control word; reserved bits read as zero.
  function automatic logic [31:0] ctl_word(
    input window_pkg::window_state_t st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CTL_ENABLE] = st.en;
    w[`CTL_POSTED] = st.posted_write_allow;
    w[`CTL_WIDTH_HI:`CTL_WIDTH_LO] = st.width;
    w[`CTL_SPACE_HI:`CTL_SPACE_LO] = st.vme_space_select;
    w[`CTL_PROGRAM] = st.program_data_am;
    w[`CTL_SUPER] = st.sup;
    w[`CTL_BLOCK] = st.block_transfer_select;
    w[`CTL_PCI_SPACE] = st.pci_space_select;
    return w;
  endfunction : ctl_word

  // Replaces only the byte lanes whose strobe is set.
  function automatic logic [31:0] merge(input logic [31:0] old_w,
    input logic [31:0] new_w, input logic [3:0] strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // True for the two spaces in which block transfers exist.
  function automatic logic blk_space(input logic [2:0] code);
    return (code == window_pkg::SPACE_A24) ||
      (code == window_pkg::SPACE_A32);
  endfunction : blk_space

  // Reserved space codes leave the window unable to claim anything.
  assign space_ok = (s.vme_space_select != window_pkg::SPACE_RSV3) &&
    (s.vme_space_select != window_pkg::SPACE_RSV4);

  // Compare and translate the offered address against the window.
  window_decoder u_decoder (
    .pci_addr(pci_addr),
    .pci_io(pci_io),
    .enable(s.en),
    .pci_space_select(s.pci_space_select),
    .space_ok(space_ok),
    .base(s.base),
    .bound(s.bound),
    .toff(s.toff),
    .hit(dec_hit),
    .vme_addr(dec_addr)
  );

  // Next-state logic for registers, bus slave and decode outputs.
  always_comb begin
    logic have_aw;
    logic have_w;
    logic [11:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [31:0] cw;
    logic [31:0] hw;
    window_pkg::reg_sel_t sel;
    have_aw = 1'b0;
    have_w = 1'b0;
    wa = 12'h000;
    wd = 32'h0000_0000;
    ws = 4'h0;
    cw = 32'h0000_0000;
    hw = 32'h0000_0000;
    sel = window_pkg::SEL_NONE;
    next_s = s;
    // Retire answers the master has accepted.
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    // Address and data may come in either order; hold whichever is first.
    have_aw = s.aw_got || (s_axi_awvalid && s_axi_awready);
    have_w = s.w_got || (s_axi_wvalid && s_axi_wready);
    wa = s.aw_got ? s.waddr : s_axi_awaddr;
    wd = s.w_got ? s.wdata : s_axi_wdata;
    ws = s.w_got ? s.wstrb : s_axi_wstrb;
    if (have_aw && have_w) begin
      // Both halves present: commit and raise the response.
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `RESP_OKAY;
      sel = reg_select(wa);
      unique case (sel)
        window_pkg::SEL_CONTROL: begin
          cw = merge(ctl_word(s), wd, ws);
          next_s.en = cw[`CTL_ENABLE];
          next_s.posted_write_allow = cw[`CTL_POSTED];
          next_s.width = cw[`CTL_WIDTH_HI:`CTL_WIDTH_LO];
          next_s.vme_space_select = cw[`CTL_SPACE_HI:`CTL_SPACE_LO];
          next_s.program_data_am = cw[`CTL_PROGRAM];
          next_s.sup = cw[`CTL_SUPER];
          next_s.block_transfer_select = cw[`CTL_BLOCK];
          next_s.pci_space_select = cw[`CTL_PCI_SPACE];
        end
        window_pkg::SEL_BASE: begin
          hw = merge({s.base, 16'h0000}, wd, ws);
          next_s.base = hw[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
        end
        window_pkg::SEL_BOUND: begin
          hw = merge({s.bound, 16'h0000}, wd, ws);
          next_s.bound = hw[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
        end
        window_pkg::SEL_OFFSET: begin
          hw = merge({s.toff, 16'h0000}, wd, ws);
          next_s.toff = hw[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
        end
        window_pkg::SEL_NONE: begin
          // Unmapped addresses store nothing and answer with an error.
          next_s.bresp = `RESP_SLVERR;
        end
      endcase
    end else begin
      // Only one half so far: keep it until the other arrives.
      if (s_axi_awvalid && s_axi_awready) begin
        next_s.aw_got = 1'b1;
        next_s.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        next_s.w_got = 1'b1;
        next_s.wdata = s_axi_wdata;
        next_s.wstrb = s_axi_wstrb;
      end
    end
    // Reads answer one cycle after the address is taken.
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `RESP_OKAY;
      unique case (reg_select(s_axi_araddr))
        window_pkg::SEL_CONTROL: next_s.rdata = ctl_word(s);
        window_pkg::SEL_BASE: next_s.rdata = {s.base, 16'h0000};
        window_pkg::SEL_BOUND: next_s.rdata = {s.bound, 16'h0000};
        window_pkg::SEL_OFFSET: next_s.rdata = {s.toff, 16'h0000};
        window_pkg::SEL_NONE: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = `RESP_SLVERR;
        end
      endcase
    end
    // Decode result is a one-cycle pulse after each offered access.
    next_s.fwd_valid = pci_valid;
    if (pci_valid) begin
      next_s.fwd_hit = dec_hit;
      next_s.fwd_addr = dec_addr;
      next_s.fwd_space = s.vme_space_select;
      next_s.fwd_width = s.width;
      next_s.fwd_program = s.program_data_am;
      next_s.fwd_super = s.sup;
      // Single block transfers only in A24/A32 below 64 bits.
      next_s.fwd_blt = s.block_transfer_select &&
        blk_space(s.vme_space_select) &&
        (s.width != window_pkg::WIDTH_64);
      // At 64 bits the block bit plays no part.
      next_s.fwd_mblt = blk_space(s.vme_space_select) &&
        (s.width == window_pkg::WIDTH_64);
      // An I/O window never posts, whatever the posting bit says.
      next_s.fwd_posted = s.posted_write_allow && !s.pci_space_select &&
        pci_write;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.width <= `RST_WIDTH;
      s.vme_space_select <= `RST_SPACE;
      s.en <= `RST_ENABLE;
      s.pci_space_select <= `RST_PCI_SPACE;
      s.base <= `RST_FIELD;
      s.bound <= `RST_FIELD;
      s.toff <= `RST_FIELD;
    end else begin
      s <= next_s;
    end
  end

  // Handshake outputs; a pending response stalls new requests.
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign fwd_valid = s.fwd_valid;
  assign fwd_hit = s.fwd_hit;
  assign fwd_vme_addr = s.fwd_addr;
  assign fwd_space = s.fwd_space;
  assign fwd_width = s.fwd_width;
  assign fwd_program = s.fwd_program;
  assign fwd_supervisor = s.fwd_super;
  assign fwd_blt = s.fwd_blt;
  assign fwd_mblt = s.fwd_mblt;
  assign fwd_posted = s.fwd_posted;

  // Checks on the decode outputs and on the reset width, all on the bus clock.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  blt_gate_a: assert property (pci_valid |=>
    fwd_blt == ($past(s.block_transfer_select) &&
    blk_space($past(s.vme_space_select)) && $past(s.width) != 2'b11))
    else $error("block transfer permission wrong");
  mblt_gate_a: assert property (fwd_mblt |-> fwd_width == 2'b11 &&
    (fwd_space == 3'b001 || fwd_space == 3'b010))
    else $error("64-bit block transfer outside A24/A32");
  // Posting is barred by the window's own space, not the access's.
  io_coupled_a: assert property (pci_valid && s.pci_space_select |=>
    !fwd_posted)
    else $error("I/O window access was posted");
  width_reset_a: assert property ($rose(aresetn) |->
    s.width == 2'b10)
    else $error("width field not 32-bit after reset");
  attr_follow_a: assert property (pci_valid |=>
    fwd_program == $past(s.program_data_am) &&
    fwd_supervisor == $past(s.sup))
    else $error("attribute bits not taken from control");
  disabled_miss_a: assert property (pci_valid && !s.en |=>
    !fwd_hit)
    else $error("disabled window claimed an access");
  bound_limit_a: assert property (pci_valid && s.bound != 16'h0000 &&
    pci_addr[31:16] >= s.bound |=> !fwd_hit)
    else $error("access at or above bound claimed");
  open_bound_a: assert property (pci_valid && s.en && space_ok &&
    pci_io == s.pci_space_select && s.bound == 16'h0000 &&
    pci_addr[31:16] >= s.base |=> fwd_hit)
    else $error("zero bound did not claim");
  translate_a: assert property (pci_valid |=>
    fwd_vme_addr[31:16] ==
    16'($past(pci_addr[31:16]) + $past(s.toff)))
    else $error("translated address wrong");
  space_match_a: assert property (pci_valid &&
    pci_io != s.pci_space_select |=> !fwd_hit)
    else $error("access of wrong PCI space claimed");

endmodule : pci_to_vme_target_window

// File: bench/pci_master_model.sv
// Behavioural PCI-side master that offers accesses to the window.
`timescale 1ns/1ps

module pci_master_model (
  // Clock.
  input wire logic aclk,
  // Request from the bench.
  input wire logic req,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic req_io,
  // Access offered to the window.
  output logic pci_valid,
  output logic [31:0] pci_addr,
  output logic pci_write,
  output logic pci_io
);
  // One offered cycle per request; idle address shows its inverse so that a
  // stale value never passes for a fresh one.
  always_ff @(posedge aclk) begin
    pci_valid <= req;
    pci_addr <= req ? req_addr : ~pci_addr;
    pci_write <= req ? req_write : ~pci_write;
    pci_io <= req ? req_io : ~pci_io;
  end
endmodule : pci_master_model

// File: bench/pci_to_vme_target_window_tb_top.sv
// Self-checking bench for the target window with a reference model.
`timescale 1ns/1ps
`include "window_defines.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module pci_to_vme_target_window_tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, req_addr = 0, pci_addr, vme;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic req = 0, req_write = 0, req_io = 0, pci_valid, pci_write, pci_io;
  logic fv, fh, fp, fs, fb, fm, fpo;
  logic [2:0] fsp;
  logic [1:0] fw;
  // Reference copies of the four registers, reserved bits already cleared.
  logic [31:0] m_ctl = 32'h0080_0000, m_base = 0, m_bound = 0, m_toff = 0;
  int error_cnt = 0, n_tests = 0, cyc = 0;

  always #4 aclk = ~aclk;

  pci_master_model pm (.aclk(aclk), .req(req), .req_addr(req_addr),
    .req_write(req_write), .req_io(req_io), .pci_valid(pci_valid),
    .pci_addr(pci_addr), .pci_write(pci_write), .pci_io(pci_io));

  pci_to_vme_target_window dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pci_valid(pci_valid),
    .pci_addr(pci_addr), .pci_write(pci_write), .pci_io(pci_io),
    .fwd_valid(fv), .fwd_hit(fh), .fwd_vme_addr(vme), .fwd_space(fsp),
    .fwd_width(fw), .fwd_program(fp), .fwd_supervisor(fs), .fwd_blt(fb),
    .fwd_mblt(fm), .fwd_posted(fpo));

  // Prints the verdict and ends the run.
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // A hang is cut short well above the few thousand cycles the tests need.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Write one word; readies are sampled mid-cycle, released after the edge.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 30; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb) `CHK("bresp", er, bresp)
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb) begin
        bready <= 0;
        return;
      end
    end
    // A response that never comes is a mismatch and ends the run.
    error_cnt++;
    report_and_stop();
  endtask : axi_wr

  // Read one word and compare data and response.
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 30; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      if (tr) begin
        `CHK("rdata", ed, rdata)
        `CHK("rresp", er, rresp)
      end
      @(posedge aclk);
      if (ta) arvalid <= 0;
      if (tr) begin
        rready <= 0;
        return;
      end
    end
    // Read data that never comes is a mismatch and ends the run.
    error_cnt++;
    report_and_stop();
  endtask : axi_rd

  // Offer one access and compare every decode output with the model.
  task automatic access(input logic [31:0] a, input logic wr, input logic io);
    logic [2:0] sp;
    logic ab, hit;
    sp = m_ctl[18:16];
    ab = (sp == 3'b001 || sp == 3'b010);
    hit = m_ctl[31] && io == m_ctl[0] && sp != 3'b011 && sp != 3'b100 &&
          a[31:16] >= m_base[31:16] &&
          (m_bound[31:16] == 0 || a[31:16] < m_bound[31:16]);
    @(posedge aclk);
    req <= 1;
    req_addr <= a;
    req_write <= wr;
    req_io <= io;
    @(posedge aclk);
    req <= 0;
    for (int n = 0; n < 4 && fv !== 1'b1; n++) begin
      @(posedge aclk);
      #1;
    end
    `CHK("fwd_valid", 1'b1, fv)
    `CHK("hit", hit, fh)
    `CHK("vme", {a[31:16] + m_toff[31:16], a[15:0]}, vme)
    `CHK("space", sp, fsp)
    `CHK("width", m_ctl[23:22], fw)
    `CHK("program", m_ctl[14], fp)
    `CHK("super", m_ctl[12], fs)
    `CHK("blt", m_ctl[8] && ab && m_ctl[23:22] != 2'b11, fb)
    `CHK("mblt", ab && m_ctl[23:22] == 2'b11, fm)
    `CHK("posted", m_ctl[30] && !m_ctl[0] && wr, fpo)
  endtask : access

  initial begin
    logic [31:0] d;
    logic [15:0] lo, a16;
    void'($urandom(15));
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    // Reset values, then read-back with reserved bits forced to zero.
    axi_rd(`OFF_CONTROL, 32'h0080_0000, `RESP_OKAY);
    axi_rd(`OFF_BASE, 0, `RESP_OKAY);
    axi_rd(`OFF_BOUND, 0, `RESP_OKAY);
    axi_rd(`OFF_OFFSET, 0, `RESP_OKAY);
    axi_wr(`OFF_CONTROL, 32'hffff_ffff, `RESP_OKAY);
    axi_rd(`OFF_CONTROL, 32'hc0c7_5101, `RESP_OKAY);
    // Only byte lane 2 written: width and space clear, the rest stays.
    wstrb <= 4'h4;
    axi_wr(`OFF_CONTROL, 32'h0000_0000, `RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(`OFF_CONTROL, 32'hc000_5101, `RESP_OKAY);
    axi_wr(12'h150, 32'h1234_5678, `RESP_SLVERR);
    axi_rd(12'h150, 0, `RESP_SLVERR);
    $display("test registers done");
    // Random windows, every code met many times; accesses near the edges.
    for (int i = 0; i < 150; i++) begin
      d = $urandom;
      d[31] = ($urandom % 4) != 0;
      m_ctl = d & 32'hc0c7_5101;
      axi_wr(`OFF_CONTROL, d, `RESP_OKAY);
      lo = $urandom;
      m_base = {lo, 16'h0000};
      d = $urandom;
      axi_wr(`OFF_BASE, {lo, d[15:0]}, `RESP_OKAY);
      a16 = ($urandom % 4 == 0) ? 16'h0000 : lo + 16'($urandom % 64) + 1;
      m_bound = {a16, 16'h0000};
      axi_wr(`OFF_BOUND, {a16, d[15:0]}, `RESP_OKAY);
      d = $urandom;
      m_toff = d & 32'hffff_0000;
      axi_wr(`OFF_OFFSET, d, `RESP_OKAY);
      axi_rd(`OFF_BASE, m_base, `RESP_OKAY);
      for (int k = 0; k < 5; k++) begin
        case (k)
          0: a16 = lo;
          1: a16 = lo - 1;
          2: a16 = m_bound[31:16] - 1;
          3: a16 = m_bound[31:16];
          default: a16 = $urandom;
        endcase
        d = $urandom;
        access({a16, d[15:0]}, d[16],
               ($urandom % 4 == 0) ? !m_ctl[0] : m_ctl[0]);
      end
    end
    $display("test decode done");
    report_and_stop();
  end
endmodule : pci_to_vme_target_window_tb_top
